// file: design/pmrc_consts.svh
/*
  Offsets, field positions, reset values and timing figures of the power
  monitor result datapath. Assumes a 100 MHz core clock.
*/
`ifndef PMRC_CONSTS_SVH
`define PMRC_CONSTS_SVH

// ----------------------------------------------------------------------
// clock and conversion times (microseconds)
// ----------------------------------------------------------------------
`define PMRC_CLK_MHZ 100
`define PMRC_CT_US0 50
`define PMRC_CT_US1 84
`define PMRC_CT_US2 150
`define PMRC_CT_US3 280
`define PMRC_CT_US4 540
`define PMRC_CT_US5 1052
`define PMRC_CT_US6 2074
`define PMRC_CT_US7 4120

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PMRC_A_CONFIG 8'h00
`define PMRC_A_ADCCFG 8'h04
`define PMRC_A_CAL 8'h08
`define PMRC_A_SHUNT 8'h0C
`define PMRC_A_BUS 8'h10
`define PMRC_A_TEMP 8'h14
`define PMRC_A_CURR 8'h18
`define PMRC_A_POWER 8'h1C
`define PMRC_A_ENE_LO 8'h20
`define PMRC_A_ENE_HI 8'h24
`define PMRC_A_CHG_LO 8'h28
`define PMRC_A_CHG_HI 8'h2C
`define PMRC_A_STATUS 8'h30

// ----------------------------------------------------------------------
// fields, reset values, scaling
// ----------------------------------------------------------------------
`define PMRC_B_RUN 0
`define PMRC_B_RANGE 1
`define PMRC_B_ACLR 2
`define PMRC_F_CT_LO 0
`define PMRC_F_AVG_LO 4
`define PMRC_RST_ADCCFG 7'h00
`define PMRC_RST_CAL 16'h0000
`define PMRC_CUR_SHIFT 12
`define PMRC_PWR_SHIFT 14
`define PMRC_ENE_FRAC 4

`endif

// file: design/pmrc_pkg.sv
/*
  Types shared by the power monitor result datapath.
  Assumes nothing of its surroundings.
*/
package pmrc_pkg;
  typedef enum logic {ST_IDLE, ST_RUN} pmrc_conv_st_t;
  typedef logic signed [19:0] pmrc_shunt_t;
  typedef logic [19:0] pmrc_bus_t;
  typedef logic signed [15:0] pmrc_temp_t;
  typedef logic [2:0] pmrc_sel_t;
endpackage

// file: design/pmrc_avg_if.sv
/*
  Carrier between the result datapath and its sample averager.
  Assumes both ends share core_clk.
*/
`timescale 1ns/100ps
interface pmrc_avg_if;
  logic smp_valid;
  pmrc_pkg::pmrc_shunt_t smp_shunt;
  pmrc_pkg::pmrc_bus_t smp_bus;
  pmrc_pkg::pmrc_temp_t smp_temp;
  pmrc_pkg::pmrc_sel_t avg_sel;
  logic restart;
  logic avg_valid;
  pmrc_pkg::pmrc_shunt_t avg_shunt;
  pmrc_pkg::pmrc_bus_t avg_bus;
  pmrc_pkg::pmrc_temp_t avg_temp;
  modport src (output smp_valid, smp_shunt, smp_bus, smp_temp, avg_sel,
    restart, input avg_valid, avg_shunt, avg_bus, avg_temp);
  modport avg (input smp_valid, smp_shunt, smp_bus, smp_temp, avg_sel,
    restart, output avg_valid, avg_shunt, avg_bus, avg_temp);
endinterface

// file: design/pmrc_avg.sv
/*
  Averager: sums 1..1024 conversions and emits their mean as one pulse.
  Assumes conversions arrive as one-cycle valid pulses.
*/
`timescale 1ns/100ps
`include "pmrc_consts.svh"
module pmrc_avg (
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset, active low
  pmrc_avg_if.avg av // samples in, means out
);
  import pmrc_pkg::*;

  function automatic logic [3:0] avg_shift(input pmrc_sel_t s);
    case (s)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction

  logic [9:0] cnt_r;
  logic signed [29:0] sh_sum_r;
  logic [29:0] bus_sum_r;
  logic signed [25:0] tp_sum_r;
  logic signed [29:0] sh_tot;
  logic [29:0] bus_tot;
  logic signed [25:0] tp_tot;
  logic [3:0] sh;
  logic last;
  logic avg_valid_r;
  pmrc_shunt_t avg_shunt_r;
  pmrc_bus_t avg_bus_r;
  pmrc_temp_t avg_temp_r;
  logic signed [29:0] sh_mean;
  logic [29:0] bus_mean;
  logic signed [25:0] tp_mean;

  always_comb begin
    sh = avg_shift(av.avg_sel);
    sh_tot = sh_sum_r + 30'(av.smp_shunt);
    bus_tot = bus_sum_r + {10'h000, av.smp_bus};
    tp_tot = tp_sum_r + 26'(av.smp_temp);
    sh_mean = sh_tot >>> sh;
    bus_mean = bus_tot >> sh;
    tp_mean = tp_tot >>> sh;
    last = (cnt_r == 10'((11'h001 << sh) - 11'h001));
  end

  // ----------------------------------------------------------------------
  // accumulate and emit
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 10'h000;
      sh_sum_r <= 30'h0;
      bus_sum_r <= 30'h0;
      tp_sum_r <= 26'h0;
      avg_valid_r <= 1'b0;
      avg_shunt_r <= 20'h0;
      avg_bus_r <= 20'h0;
      avg_temp_r <= 16'h0;
    end else begin
      avg_valid_r <= 1'b0;
      if (av.restart) begin
        cnt_r <= 10'h000;
        sh_sum_r <= 30'h0;
        bus_sum_r <= 30'h0;
        tp_sum_r <= 26'h0;
      end else if (av.smp_valid && last) begin
        cnt_r <= 10'h000;
        sh_sum_r <= 30'h0;
        bus_sum_r <= 30'h0;
        tp_sum_r <= 26'h0;
        avg_valid_r <= 1'b1;
        avg_shunt_r <= sh_mean[19:0];
        avg_bus_r <= bus_mean[19:0];
        avg_temp_r <= tp_mean[15:0];
      end else if (av.smp_valid) begin
        cnt_r <= cnt_r + 10'h001;
        sh_sum_r <= sh_tot;
        bus_sum_r <= bus_tot;
        tp_sum_r <= tp_tot;
      end
    end
  end

  assign av.avg_valid = avg_valid_r;
  assign av.avg_shunt = avg_shunt_r;
  assign av.avg_bus = avg_bus_r;
  assign av.avg_temp = avg_temp_r;

  AST_AVG_COUNT: assert property (@(posedge core_clk) disable iff (!arst_n)
    av.smp_valid && !av.restart && !last |=> !avg_valid_r)
    else $error("mean emitted before the averaging count was reached");
endmodule

// file: design/pmrc_top.sv
/*
  Result formatting and calculation datapath of a shunt power monitor:
  conversion pacing, averaging, current, power, energy and charge.
  Assumes an ADC front end that answers each start pulse with one
  adc_done pulse and synchronous data, and a register master on a plain
  strobe port.
*/
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "pmrc_consts.svh"

// Function
// - range bit picks 163.84 or 40.96 mV scale
// - bus result unsigned, 195.3125 uV steps
// - shunt and bus results are 20 bits
// - shunt result is signed
// - temperature signed 16 bits, 7.8125 mC
// - current from each shunt result times calibration
// - zero calibration gives zero current
// - power is 24-bit unsigned, 3.2 current steps
// - energy 40-bit unsigned, 16 power steps
// - charge 40-bit two's complement
// - accumulators wrap on overflow
// - clear bit empties both accumulators anytime
// - eight conversion times, 50 to 4120 us
// - average 1..1024; period is time times count
module pmrc_top #(
  parameter int unsigned CYC_PER_US = `PMRC_CLK_MHZ // shorten in sim
) (
  input wire logic core_clk, // core clock, 100 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after reg_rd
  output logic adc_start, // conversion start pulse
  output logic adc_range, // shunt_range_select to front end
  input wire logic adc_done, // conversion finished pulse
  input wire pmrc_pkg::pmrc_shunt_t adc_shunt, // raw shunt code
  input wire pmrc_pkg::pmrc_bus_t adc_bus, // raw bus code
  input wire pmrc_pkg::pmrc_temp_t adc_temp, // raw die temperature
  output logic result_ready // pulse on each result update
);
  import pmrc_pkg::*;

  function automatic logic [19:0] conv_cyc(input pmrc_sel_t s);
    int unsigned us;
    case (s)
      3'h0: us = `PMRC_CT_US0;
      3'h1: us = `PMRC_CT_US1;
      3'h2: us = `PMRC_CT_US2;
      3'h3: us = `PMRC_CT_US3;
      3'h4: us = `PMRC_CT_US4;
      3'h5: us = `PMRC_CT_US5;
      3'h6: us = `PMRC_CT_US6;
      default: us = `PMRC_CT_US7;
    endcase
    conv_cyc = 20'(us * CYC_PER_US);
  endfunction

  // ----------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------
  logic wr_cfg;
  logic wr_adc;
  logic wr_cal;
  logic rd_stat;
  logic acc_clear;
  logic run_r;
  logic range_r;
  pmrc_sel_t ct_sel_r;
  pmrc_sel_t avg_sel_r;
  logic [15:0] cal_r;

  always_comb begin
    wr_cfg = 1'b0;
    wr_adc = 1'b0;
    wr_cal = 1'b0;
    if (reg_wr && reg_addr == `PMRC_A_CONFIG) begin
      wr_cfg = 1'b1;
    end else if (reg_wr && reg_addr == `PMRC_A_ADCCFG) begin
      wr_adc = 1'b1;
    end else if (reg_wr && reg_addr == `PMRC_A_CAL) begin
      wr_cal = 1'b1;
    end
    rd_stat = reg_rd && reg_addr == `PMRC_A_STATUS;
    acc_clear = wr_cfg && reg_wdata[`PMRC_B_ACLR];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r <= 1'b0;
      range_r <= 1'b0;
    end else if (wr_cfg) begin
      run_r <= reg_wdata[`PMRC_B_RUN];
      range_r <= reg_wdata[`PMRC_B_RANGE];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {avg_sel_r, ct_sel_r} <= 6'(`PMRC_RST_ADCCFG);
    end else if (wr_adc) begin
      ct_sel_r <= reg_wdata[`PMRC_F_CT_LO +: 3];
      avg_sel_r <= reg_wdata[`PMRC_F_AVG_LO +: 3];
    end
  end

  // host supplies the scaling; narrow range expects it four times larger
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_r <= `PMRC_RST_CAL;
    end else if (wr_cal) begin
      cal_r <= reg_wdata[15:0];
    end
  end

  assign adc_range = range_r;

  // ----------------------------------------------------------------------
  // conversion pacing
  // ----------------------------------------------------------------------
  pmrc_conv_st_t st_r;
  logic [19:0] timer_r;
  logic start_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      timer_r <= 20'h0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          timer_r <= 20'h0;
          if (run_r) begin
            st_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!run_r || wr_adc) begin
            st_r <= ST_IDLE;
          end else if (timer_r == 20'h0) begin
            start_r <= 1'b1;
            timer_r <= conv_cyc(ct_sel_r) - 20'h1;
          end else begin
            timer_r <= timer_r - 20'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign adc_start = start_r;

  // ----------------------------------------------------------------------
  // averaging
  // ----------------------------------------------------------------------
  pmrc_avg_if av_if ();

  // a new averaging setting discards a half-built sum
  assign av_if.smp_valid = adc_done && st_r == ST_RUN;
  assign av_if.smp_shunt = adc_shunt;
  assign av_if.smp_bus = adc_bus;
  assign av_if.smp_temp = adc_temp;
  assign av_if.avg_sel = avg_sel_r;
  assign av_if.restart = wr_adc || st_r == ST_IDLE;

  pmrc_avg u_avg (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .av(av_if.avg)
  );

  // ----------------------------------------------------------------------
  // current and power
  // ----------------------------------------------------------------------
  logic signed [36:0] cur_prod;
  pmrc_shunt_t cur_nxt;
  logic [19:0] cur_mag;
  logic [39:0] pwr_prod;
  logic [23:0] pwr_nxt;

  always_comb begin
    cur_prod = av_if.avg_shunt * $signed({1'b0, cal_r});
    if (cal_r == 16'h0000) begin
      cur_nxt = 20'h0;
    end else begin
      cur_nxt = cur_prod[`PMRC_CUR_SHIFT +: 20];
    end
    cur_mag = cur_nxt[19] ? 20'(-cur_nxt) : cur_nxt;
    pwr_prod = cur_mag * av_if.avg_bus;
    // clip rather than fold a too-large product into a small reading
    if (|pwr_prod[39:`PMRC_PWR_SHIFT + 24]) begin
      pwr_nxt = 24'hFFFFFF;
    end else begin
      pwr_nxt = pwr_prod[`PMRC_PWR_SHIFT +: 24];
    end
  end

  // ----------------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------------
  pmrc_shunt_t shunt_r;
  pmrc_bus_t bus_r;
  pmrc_temp_t temp_r;
  pmrc_shunt_t cur_r;
  logic [23:0] pwr_r;
  logic rdy_r;
  logic upd_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shunt_r <= 20'h0;
      bus_r <= 20'h0;
      temp_r <= 16'h0;
      cur_r <= 20'h0;
      pwr_r <= 24'h0;
    end else if (av_if.avg_valid) begin
      shunt_r <= av_if.avg_shunt;
      bus_r <= av_if.avg_bus;
      temp_r <= av_if.avg_temp;
      cur_r <= cur_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  // ready flag: a new result beats a status read in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_r <= 1'b0;
      upd_r <= 1'b0;
    end else begin
      upd_r <= av_if.avg_valid;
      if (av_if.avg_valid) begin
        rdy_r <= 1'b1;
      end else if (rd_stat) begin
        rdy_r <= 1'b0;
      end
    end
  end

  assign result_ready = upd_r;

  // ----------------------------------------------------------------------
  // energy and charge accumulators
  // ----------------------------------------------------------------------
  logic [39 + `PMRC_ENE_FRAC:0] ene_r;
  logic [39:0] chg_r;

  // a clear in the same cycle as a sample drops that sample
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ene_r <= '0;
      chg_r <= 40'h0;
    end else if (acc_clear) begin
      ene_r <= '0;
      chg_r <= 40'h0;
    end else if (av_if.avg_valid) begin
      ene_r <= ene_r + (39 + `PMRC_ENE_FRAC + 1)'(pwr_nxt);
      chg_r <= chg_r + 40'(cur_nxt);
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = 32'h0;
    if (reg_addr == `PMRC_A_CONFIG) begin
      rd_nxt = 32'({range_r, run_r});
    end else if (reg_addr == `PMRC_A_ADCCFG) begin
      rd_nxt = 32'({1'b0, avg_sel_r, 1'b0, ct_sel_r});
    end else if (reg_addr == `PMRC_A_CAL) begin
      rd_nxt = 32'(cal_r);
    end else if (reg_addr == `PMRC_A_SHUNT) begin
      rd_nxt = {12'h000, shunt_r};
    end else if (reg_addr == `PMRC_A_BUS) begin
      rd_nxt = {12'h000, bus_r};
    end else if (reg_addr == `PMRC_A_TEMP) begin
      rd_nxt = {16'h0000, temp_r};
    end else if (reg_addr == `PMRC_A_CURR) begin
      rd_nxt = {12'h000, cur_r};
    end else if (reg_addr == `PMRC_A_POWER) begin
      rd_nxt = {8'h00, pwr_r};
    end else if (reg_addr == `PMRC_A_ENE_LO) begin
      rd_nxt = ene_r[`PMRC_ENE_FRAC +: 32];
    end else if (reg_addr == `PMRC_A_ENE_HI) begin
      rd_nxt = {24'h0, ene_r[`PMRC_ENE_FRAC + 32 +: 8]};
    end else if (reg_addr == `PMRC_A_CHG_LO) begin
      rd_nxt = chg_r[31:0];
    end else if (reg_addr == `PMRC_A_CHG_HI) begin
      rd_nxt = {24'h0, chg_r[39:32]};
    end else if (reg_addr == `PMRC_A_STATUS) begin
      rd_nxt = 32'({st_r == ST_RUN, rdy_r});
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [19:0] gap_r;
  logic seen_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 20'h0;
      seen_r <= 1'b0;
    end else if (wr_adc || st_r == ST_IDLE) begin
      gap_r <= 20'h0;
      seen_r <= 1'b0;
    end else if (start_r) begin
      gap_r <= 20'h1;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 20'h1;
    end
  end

  AST_RANGE: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_cfg |=> adc_range == $past(reg_wdata[`PMRC_B_RANGE]))
    else $error("range output does not follow the config write");
  AST_CAL_ZERO: assert property (@(posedge core_clk) disable iff (!arst_n)
    av_if.avg_valid && cal_r == 16'h0 |=> cur_r == 20'h0)
    else $error("current not zero under zero calibration");
  AST_CURRENT: assert property (@(posedge core_clk) disable iff (!arst_n)
    av_if.avg_valid && cal_r != 16'h0
    |=> cur_r == $past(cur_prod[`PMRC_CUR_SHIFT +: 20]))
    else $error("current is not shunt result times calibration");
  AST_SHUNT: assert property (@(posedge core_clk) disable iff (!arst_n)
    av_if.avg_valid |=> shunt_r == $past(av_if.avg_shunt))
    else $error("shunt result not taken from the averaged sample");
  AST_BUS_TEMP: assert property (@(posedge core_clk) disable iff (!arst_n)
    av_if.avg_valid |=> bus_r == $past(av_if.avg_bus)
    && temp_r == $past(av_if.avg_temp) && upd_r)
    else $error("bus or temperature result not updated");
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (!arst_n)
    acc_clear |=> ene_r == '0 && chg_r == 40'h0)
    else $error("accumulators not cleared");
  AST_CHARGE: assert property (@(posedge core_clk) disable iff (!arst_n)
    av_if.avg_valid && !acc_clear
    |=> chg_r == 40'($past(chg_r) + 40'($past(cur_nxt))))
    else $error("charge did not add the new current");
  AST_ENERGY: assert property (@(posedge core_clk) disable iff (!arst_n)
    !av_if.avg_valid && !acc_clear |=> $stable(ene_r))
    else $error("energy moved without an averaged sample");
  AST_PERIOD: assert property (@(posedge core_clk) disable iff (!arst_n)
    start_r && seen_r |-> gap_r == conv_cyc(ct_sel_r))
    else $error("start spacing differs from the conversion time");

  COV_AVG: cover property (@(posedge core_clk) disable iff (!arst_n)
    av_if.avg_valid && avg_sel_r == 3'h1);
  COV_CLEAR: cover property (@(posedge core_clk) disable iff (!arst_n)
    acc_clear && chg_r != 40'h0);
  COV_NEG: cover property (@(posedge core_clk) disable iff (!arst_n)
    av_if.avg_valid && cur_nxt[19]);
endmodule

// file: verif/pmrc_top_tb.sv
/*
  Self-checking bench for the power monitor result datapath: register
  reset values, formatting, current and power, accumulators, clear,
  range select, averaging and conversion pacing.
  Assumes the bench acts as the ADC front end, answering each start
  pulse with one done pulse, and the design built with CYC_PER_US = 1.
*/
`timescale 1ns/100ps
`include "pmrc_consts.svh"
module pmrc_top_tb;
  import pmrc_pkg::*;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic core_clk;
  logic arst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic adc_start;
  logic adc_range;
  logic adc_done;
  pmrc_shunt_t adc_shunt;
  pmrc_bus_t adc_bus;
  pmrc_temp_t adc_temp;
  logic result_ready;
  int n_mismatch;
  int compares;
  int cyc;
  int ct_us [8] = '{`PMRC_CT_US0, `PMRC_CT_US1, `PMRC_CT_US2, `PMRC_CT_US3,
    `PMRC_CT_US4, `PMRC_CT_US5, `PMRC_CT_US6, `PMRC_CT_US7};

  // one cycle per microsecond keeps the slowest setting at 4120 cycles
  pmrc_top #(.CYC_PER_US(1)) uut (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .adc_start(adc_start),
    .adc_range(adc_range),
    .adc_done(adc_done),
    .adc_shunt(adc_shunt),
    .adc_bus(adc_bus),
    .adc_temp(adc_temp),
    .result_ready(result_ready)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [39:0] exp,
    input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
    input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  // front end: wait for a start, answer with one done pulse
  task automatic conv(input logic [19:0] sh, input logic [19:0] bu,
    input logic [15:0] te, output int t_st, output int t_rdy);
    int n;
    n = 0;
    t_rdy = -1;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (adc_start !== 1'b1 && n < 6000);
    chk("adc_start_seen", 1, adc_start);
    t_st = cyc;
    @(posedge core_clk);
    adc_done <= 1'b1;
    adc_shunt <= sh;
    adc_bus <= bu;
    adc_temp <= te;
    @(posedge core_clk);
    adc_done <= 1'b0;
    adc_shunt <= ~sh;
    adc_bus <= ~bu;
    adc_temp <= ~te;
    repeat (4) begin
      @(posedge core_clk);
      #1;
      if (result_ready === 1'b1) t_rdy = cyc;
    end
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    rchk(`PMRC_A_CONFIG, 32'h0, "config");
    rchk(`PMRC_A_ADCCFG, 32'h0, "adc_cfg");
    rchk(`PMRC_A_CAL, 32'h0, "shunt_cal");
    wr(8'h40, 32'hFFFFFFFF);
    rchk(8'h40, 32'h0, "unmapped");
  endtask

  task automatic t_cal_zero;
    int ts;
    int tr;
    wr(`PMRC_A_CONFIG, 32'h1);
    rchk(`PMRC_A_STATUS, 32'h2, "status_running");
    conv(20'hFFC18, 20'h04000, 16'hFC00, ts, tr);
    wr(`PMRC_A_CONFIG, 32'h0);
    chk("result_ready", 1, tr >= 0);
    rchk(`PMRC_A_STATUS, 32'h1, "status_ready");
    rchk(`PMRC_A_STATUS, 32'h0, "status_read_clr");
    rchk(`PMRC_A_SHUNT, 32'h000FFC18, "shunt");
    rchk(`PMRC_A_BUS, 32'h00004000, "bus");
    rchk(`PMRC_A_TEMP, 32'h0000FC00, "temp");
    rchk(`PMRC_A_CURR, 32'h0, "current_cal0");
    rchk(`PMRC_A_POWER, 32'h0, "power_cal0");
  endtask

  // -1000 * 4096 >> 12 = -1000; power 1000 * 16384 >> 14 = 1000
  task automatic t_calc;
    int ts;
    int tr;
    wr(`PMRC_A_CAL, 32'h1000);
    wr(`PMRC_A_CONFIG, 32'h1);
    repeat (2) conv(20'hFFC18, 20'h04000, 16'h0100, ts, tr);
    wr(`PMRC_A_CONFIG, 32'h0);
    rchk(`PMRC_A_CURR, 32'h000FFC18, "current");
    rchk(`PMRC_A_POWER, 32'h000003E8, "power");
    rchk(`PMRC_A_ENE_LO, 32'h0000007D, "energy_lo");
    rchk(`PMRC_A_ENE_HI, 32'h0, "energy_hi");
    rchk(`PMRC_A_CHG_LO, 32'hFFFFF830, "charge_lo");
    rchk(`PMRC_A_CHG_HI, 32'h000000FF, "charge_hi");
  endtask

  // largest current on the highest bus code must clip the power word
  task automatic t_sat;
    int ts;
    int tr;
    wr(`PMRC_A_CONFIG, 32'h1);
    conv(20'h7FFFF, 20'hFFFFF, 16'h0000, ts, tr);
    wr(`PMRC_A_CONFIG, 32'h0);
    rchk(`PMRC_A_CURR, 32'h0007FFFF, "current_max");
    rchk(`PMRC_A_POWER, 32'h00FFFFFF, "power_sat");
  endtask

  task automatic t_clear;
    wr(`PMRC_A_CONFIG, 32'h4);
    rchk(`PMRC_A_ENE_LO, 32'h0, "energy_lo_clr");
    rchk(`PMRC_A_ENE_HI, 32'h0, "energy_hi_clr");
    rchk(`PMRC_A_CHG_LO, 32'h0, "charge_lo_clr");
    rchk(`PMRC_A_CHG_HI, 32'h0, "charge_hi_clr");
    rchk(`PMRC_A_CONFIG, 32'h0, "config_clr_bit");
  endtask

  task automatic t_range;
    wr(`PMRC_A_CONFIG, 32'h2);
    #1;
    chk("adc_range_narrow", 1, adc_range);
    rchk(`PMRC_A_CONFIG, 32'h2, "config_range");
    wr(`PMRC_A_CONFIG, 32'h0);
    #1;
    chk("adc_range_wide", 0, adc_range);
  endtask

  // four samples per result; second mean is (500+600+700+800)/4
  task automatic t_avg;
    int ts;
    int tr [8];
    wr(`PMRC_A_ADCCFG, 32'h10);
    wr(`PMRC_A_CONFIG, 32'h1);
    for (int i = 0; i < 8; i++) begin
      conv(20'(i * 100 + 100), 20'h00100, 16'h0010, ts, tr[i]);
    end
    wr(`PMRC_A_CONFIG, 32'h0);
    for (int i = 0; i < 8; i++) begin
      chk("avg_ready", (i % 4) == 3, tr[i] >= 0);
    end
    chk("out_period", 4 * ct_us[0], tr[7] - tr[3]);
    rchk(`PMRC_A_SHUNT, 32'h0000028A, "avg_shunt");
    // sixteen samples: mean of 0, 16, .., 240 is 120
    wr(`PMRC_A_ADCCFG, 32'h20);
    wr(`PMRC_A_CONFIG, 32'h1);
    for (int i = 0; i < 16; i++) begin
      conv(20'(i * 16), 20'h00100, 16'h0010, ts, tr[0]);
      chk("avg16_ready", i == 15, tr[0] >= 0);
    end
    wr(`PMRC_A_CONFIG, 32'h0);
    rchk(`PMRC_A_SHUNT, 32'h00000078, "avg16_shunt");
  endtask

  task automatic t_ctime;
    int t1;
    int t2;
    int tr;
    for (int s = 0; s < 8; s++) begin
      wr(`PMRC_A_ADCCFG, 32'(s));
      wr(`PMRC_A_CONFIG, 32'h1);
      conv(20'h00010, 20'h00100, 16'h0010, t1, tr);
      conv(20'h00010, 20'h00100, 16'h0010, t2, tr);
      wr(`PMRC_A_CONFIG, 32'h0);
      chk("conv_period", ct_us[s], t2 - t1);
    end
  endtask

  // ------------------------------------------------------------------
  // run control
  // ------------------------------------------------------------------
  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // whole run is about 10000 cycles, mostly the pacing sweep
  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    adc_done = 1'b0;
    adc_shunt = 20'h0;
    adc_bus = 20'h0;
    adc_temp = 16'h0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_cal_zero();
    t_calc();
    t_sat();
    t_clear();
    t_range();
    t_avg();
    t_ctime();
    wrap_up();
  end
endmodule
